// [logic/sdp_top.sv]
// serial datagram slave: 40-bit frames, pipelined read-back, status byte
//
// Summary of operation
// - frame is 40 bits: address or status byte on top, 32 data bits below.
// - frame bit 39 picks direction: zero reads, one writes.
// - a full 40-bit answer is shifted out in every frame of 40 clocks or more.
// - after a read frame, returned data is the register it addressed.
// - after a write frame, returned data repeats that frame's write data.
// - read frames only pass the address; their data bits are never stored.
// - bits 39 to 32 of each answer carry the eight-flag status byte.
// - status flags are captured at frame end, shown in the next frame.
// - status bits 7 and 6 mirror the right and left stop switches.
// - status bits 5 and 4 mirror position reached and velocity reached.
// - status bits 3 and 2 mirror standstill and stall detection.
// - status bits 1 and 0 mirror driver error and reset occurred.
// - register data is right aligned within the 32 data bits.
// - bits go msb first; sample on rising, update out after falling edge.
// - select rising takes last 40 bits; extra bits leave 40 clocks later.
`timescale 1ns/1ps
module sdp_top #(
    parameter int DATA_W = 32,
    parameter int ADDR_W = 7
) (
    input  wire logic                        mclk,
    input  wire logic                        nrst,
    input  wire logic                        sck,
    input  wire logic                        select_low,
    input  wire logic                        serial_in,
    output logic                             serial_out,
    output logic                             serial_out_oe_n,
    input  wire sdp_pkg::sdp_status_s        status_flags,
    input  wire logic [DATA_W-1:0]           reg_rdata,
    output sdp_pkg::sdp_req_s                reg_req,
    output logic                             frame_error
);
    // the frame layout is fixed; other widths cannot be served
    if (DATA_W != sdp_pkg::DATA_BITS || ADDR_W != sdp_pkg::ADDR_BITS) begin : g_chk
        $error("sdp_top supports only 32 data bits and 7 address bits");
    end

    // timing budget, counted in system clocks:
    //   every pin passes two synchroniser flops, and sck and select one edge flop, so the
    //   logic sees a pin change about three clocks after it happens
    //   the first answer bit appears one clock after the select fall is seen
    //   later answer bits change one clock after each bus clock fall is seen
    //   the command is acted on one clock after the select rise is seen
    // limits that follow from this:
    //   each bus clock phase must last at least three system clocks,
    //   otherwise an edge can be lost between two samples
    //   select must stay high for at least three clocks between frames,
    //   or the end of one frame and the start of the next merge
    //   the answer is loaded at the select fall, so a read fetch must have
    //   landed by then; the bypass below covers the one-clock overlap
    // hazards avoided:
    //   bus clock edges are counted only while select is low, so a master
    //   that toggles the clock while deselected leaves the counter alone
    //   because all three pins share the same delay, the last rising edge
    //   of a frame is always counted before the select rise is seen
    //   serial_out keeps its last bit when deselected; the enable going
    //   high is what releases the line
    // trade-off: no extra filter on the pins; a glitch shorter than one
    //   system clock may be seen as an edge if it straddles a sample
    // limitation: the register side must answer a read in the same cycle as
    //   the read strobe; a slower register file needs a longer fetch state
    // limitation: a frame that is cut short returns nothing useful to the
    //   master, but the status byte is still refreshed at its end
    // reading a register costs two frames; chained reads hide that cost,
    //   since each frame carries the result of the one before
    // data before the first read or write is the reset value of the
    //   read-back word, zero, and holds no register content

    logic [2:0]                          pins_s;
    logic                                sck_s;
    logic                                csn_s;
    logic                                sdi_s;
    logic [1:0]                          edge_rise;
    logic [1:0]                          edge_fall;
    logic                                sck_rise;
    logic                                sck_fall;
    logic                                csn_rise;
    logic                                csn_fall;
    logic [sdp_pkg::FRAME_BITS-1:0]      shift_r;
    logic [sdp_pkg::FRAME_BITS-1:0]      answer;
    logic [sdp_pkg::CNT_BITS-1:0]        bit_cnt_r;
    logic                                out_r;
    logic                                oe_n_r;
    sdp_pkg::sdp_status_s                status_r;
    logic [sdp_pkg::DATA_BITS-1:0]       readback_r;
    logic [sdp_pkg::DATA_BITS-1:0]       readback_now;
    sdp_pkg::sdp_state_e                 state_r;
    sdp_pkg::sdp_req_s                   req_r;
    logic                                err_r;
    logic                                frame_ok;
    logic                                cmd_write;
    logic [sdp_pkg::ADDR_BITS-1:0]       cmd_addr;
    logic [sdp_pkg::DATA_BITS-1:0]       cmd_data;

    // pins come from the master's domain: two flops before any use
    // one three-bit synchroniser keeps sck, select and data aligned
    sdp_sync #(
        .WIDTH   (3),
        .STAGES  (sdp_pkg::SYNC_STAGES),
        .RST_VAL (sdp_pkg::PIN_SYNC_RST)
    ) u_sync (
        .mclk (mclk),
        .nrst (nrst),
        .d    ({sck, select_low, serial_in}),
        .q    (pins_s)
    );

    assign sck_s = pins_s[2];
    assign csn_s = pins_s[1];
    assign sdi_s = pins_s[0];

    // edges of the synchronised bus clock and select
    // reset values match the idle pin levels, so no false edge follows reset
    sdp_edge #(
        .WIDTH   (2),
        .RST_VAL (sdp_pkg::PIN_EDGE_RST)
    ) u_edge (
        .mclk (mclk),
        .nrst (nrst),
        .d    ({sck_s, csn_s}),
        .rise (edge_rise),
        .fall (edge_fall)
    );

    // bus clock edges only count while selected
    assign sck_rise = edge_rise[1] & ~csn_s;
    assign sck_fall = edge_fall[1] & ~csn_s;
    assign csn_rise = edge_rise[0];
    assign csn_fall = edge_fall[0];

    // command fields of the last 40 bits received
    // fields are read straight from the shifter; they are only valid at the
    // select rise, which is the only time they are used
    // split frame fields
    assign cmd_write = shift_r[sdp_pkg::DIR_POS];
    assign cmd_addr  = shift_r[sdp_pkg::ADDR_HI:sdp_pkg::ADDR_LO];
    assign cmd_data  = shift_r[sdp_pkg::DATA_HI:sdp_pkg::DATA_LO];

    // forty counted rises or more make a frame acceptable
    // short frames are dropped
    assign frame_ok = (bit_cnt_r == sdp_pkg::FRAME_CNT);

    // a read fetch may still be landing when the next frame starts; bypass it
    assign readback_now = (state_r == sdp_pkg::SDP_FETCH) ? reg_rdata : readback_r;

    // status byte on top, data below
    assign answer = {status_r, readback_now};

    // bit counter saturates at a full frame; excess bits only pass through
    // saturation keeps a long daisy-chain frame from wrapping the count
    // back below 40 and being refused as short
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bit_cnt_r <= '0;
        end else if (csn_fall) begin
            bit_cnt_r <= '0;
        end else if (sck_rise && bit_cnt_r != sdp_pkg::FRAME_CNT) begin
            bit_cnt_r <= bit_cnt_r + 6'h01;
        end
    end

    // one register serves as both answer and receive shifter, which gives
    // the 40-clock pass-through of excess bits for free
    // the answer is loaded at the select fall, not at the end of the
    // previous frame, so the freshest read-back is sent
    // load answer every frame
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            shift_r <= '0;
        end else if (csn_fall) begin
            shift_r <= answer;
        end else if (sck_rise) begin
            shift_r <= {shift_r[sdp_pkg::FRAME_BITS-2:0], sdi_s};
        end
    end

    // serial output changes after the falling bus clock edge only
    // the first bit is set at the select fall, so it is already out before the
    // first falling edge, which mode 3 gives ahead of the first rising one
    // update out on falling
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            out_r <= 1'b0;
        end else if (csn_fall) begin
            out_r <= answer[sdp_pkg::FRAME_BITS-1];
        end else if (sck_fall) begin
            out_r <= shift_r[sdp_pkg::FRAME_BITS-1];
        end
    end

    // output enable low while selected
    // enable follows the synchronised select, so it lags the pin by about
    // three clocks at both ends of a frame
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            oe_n_r <= 1'b1;
        end else if (csn_fall) begin
            oe_n_r <= 1'b0;
        end else if (csn_rise) begin
            oe_n_r <= 1'b1;
        end
    end

    // status is latched at the end of every access, good or short
    // a short frame still refreshes the status, so the master always sees
    // flags no older than its last select rise
    // the sticky error and reset flags are cleared outside, on a read of
    // the global state register; here they are only copied
    // capture flags at frame end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            status_r <= sdp_pkg::STAT_RST;
        end else if (csn_rise) begin
            status_r <= status_flags;
        end
    end

    // fetch state waits one cycle for the register file's read data
    // the register file answers in the same cycle as the read strobe; a
    // single wait state is enough and keeps the path short
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_r <= sdp_pkg::SDP_IDLE;
        end else begin
            case (state_r)
                sdp_pkg::SDP_IDLE: begin
                    if (csn_rise && frame_ok && !cmd_write) begin
                        state_r <= sdp_pkg::SDP_FETCH;
                    end
                end
                sdp_pkg::SDP_FETCH: begin
                    state_r <= sdp_pkg::SDP_IDLE;
                end
                default: begin
                    state_r <= sdp_pkg::SDP_IDLE;
                end
            endcase
        end
    end

    // read-back word for the next frame
    // a read loads what the register file returned, a write the data just
    // received; a short frame leaves the word as it was
    // zero until first read or write
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            readback_r <= sdp_pkg::READBACK_RST;
        end else if (state_r == sdp_pkg::SDP_FETCH) begin
            readback_r <= reg_rdata;
        end else if (csn_rise && frame_ok && cmd_write) begin
            readback_r <= cmd_data;
        end
    end

    // register request: one-cycle strobes, address and data held
    // write data is kept from the last write only, so a read frame's dummy
    // data bits never reach the register side
    // direction from bit 39
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            req_r.wr    <= 1'b0;
            req_r.rd    <= 1'b0;
            req_r.addr  <= sdp_pkg::ADDR_RST;
            req_r.wdata <= sdp_pkg::READBACK_RST;
        end else begin
            req_r.wr <= csn_rise & frame_ok & cmd_write;
            req_r.rd <= csn_rise & frame_ok & ~cmd_write;
            if (csn_rise && frame_ok) begin
                req_r.addr <= cmd_addr;
            end
            if (csn_rise && frame_ok && cmd_write) begin
                req_r.wdata <= cmd_data;
            end
        end
    end

    // a frame shorter than 40 clocks flags an error pulse
    // the pulse is for a monitor; the frame itself is simply dropped
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            err_r <= 1'b0;
        end else begin
            err_r <= csn_rise & ~frame_ok;
        end
    end

    // every output comes straight from a flop, so no pin path sees a glitch
    assign serial_out      = out_r;
    assign serial_out_oe_n = oe_n_r;
    assign reg_req         = req_r;
    assign frame_error     = err_r;
endmodule

// [logic/sdp_pkg.sv]
// shared constants and types of the serial datagram access pipeline
package sdp_pkg;
    localparam int FRAME_BITS  = 40;
    localparam int DATA_BITS   = 32;
    localparam int ADDR_BITS   = 7;
    localparam int STAT_BITS   = 8;
    localparam int DIR_POS     = 39;
    localparam int ADDR_HI     = 38;
    localparam int ADDR_LO     = 32;
    localparam int DATA_HI     = 31;
    localparam int DATA_LO     = 0;
    localparam int SYNC_STAGES = 2;
    localparam int CNT_BITS    = 6;
    localparam logic [CNT_BITS-1:0]  FRAME_CNT     = 6'h28;
    localparam logic [STAT_BITS-1:0] STAT_RST      = 8'h00;
    localparam logic [DATA_BITS-1:0] READBACK_RST  = 32'h00000000;
    localparam logic [ADDR_BITS-1:0] ADDR_RST      = 7'h00;
    localparam logic [2:0]           PIN_SYNC_RST  = 3'h6;
    localparam logic [1:0]           PIN_EDGE_RST  = 2'h3;

    // status byte, field order equals bit order 7 down to 0
    typedef struct packed {
        logic stop_right;
        logic stop_left;
        logic pos_reached;
        logic vel_reached;
        logic standstill;
        logic stall_detect_flag;
        logic driver_error;
        logic reset_flag;
    } sdp_status_s;

    // register access request toward the register file
    typedef struct packed {
        logic                 wr;
        logic                 rd;
        logic [ADDR_BITS-1:0] addr;
        logic [DATA_BITS-1:0] wdata;
    } sdp_req_s;

    typedef enum logic [0:0] {
        SDP_IDLE,
        SDP_FETCH
    } sdp_state_e;
endpackage

// [logic/sdp_sync.sv]
// multi-bit two-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
module sdp_sync #(
    parameter int         WIDTH   = 1,
    parameter int         STAGES  = 2,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             mclk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage_r [STAGES];

    if (STAGES < 2) begin : g_chk
        $error("sdp_sync needs at least two stages");
    end

    // first stage is read only by the next stage
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < STAGES; i++) begin
                stage_r[i] <= RST_VAL;
            end
        end else begin
            stage_r[0] <= d;
            for (int i = 1; i < STAGES; i++) begin
                stage_r[i] <= stage_r[i-1];
            end
        end
    end

    assign q = stage_r[STAGES-1];
endmodule

// [logic/sdp_edge.sv]
// rising and falling edge finder for already synchronised levels
`timescale 1ns/1ps
module sdp_edge #(
    parameter int         WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             mclk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] prev_r;

    // previous sample of each level
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prev_r <= RST_VAL;
        end else begin
            prev_r <= d;
        end
    end

    // one-cycle pulses, per bit
    assign rise = d & ~prev_r;
    assign fall = ~d & prev_r;
endmodule

// [verification/sdp_top_props.sv]
// port-level assertions for the serial datagram slave
`timescale 1ns/1ps
module sdp_top_props #(
    parameter int DATA_W = 32,
    parameter int ADDR_W = 7
) (
    input wire logic                 mclk,
    input wire logic                 nrst,
    input wire logic                 sck,
    input wire logic                 select_low,
    input wire logic                 serial_in,
    input wire logic                 serial_out,
    input wire logic                 serial_out_oe_n,
    input wire sdp_pkg::sdp_status_s status_flags,
    input wire logic [DATA_W-1:0]    reg_rdata,
    input wire sdp_pkg::sdp_req_s    reg_req,
    input wire logic                 frame_error
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    logic req;
    // any accepted command, read or write
    assign req = reg_req.wr | reg_req.rd;
    a_req_one_kind: assert property (!(reg_req.wr && reg_req.rd))
        else $error("read and write requested together");
    a_wr_one_pulse: assert property (reg_req.wr |=> !reg_req.wr)
        else $error("write request longer than one cycle");
    a_rd_one_pulse: assert property (reg_req.rd |=> !reg_req.rd)
        else $error("read request longer than one cycle");
    a_req_after_end: assert property (req |-> select_low)
        else $error("command issued while select still low");
    a_idle_no_drive: assert property (select_low [*4] |-> serial_out_oe_n)
        else $error("output driven while deselected");
    a_frame_drives_out: assert property (!select_low [*6] |-> !serial_out_oe_n)
        else $error("output not driven during frame");
    a_wdata_only_write: assert property (!reg_req.wr |-> $stable(reg_req.wdata))
        else $error("write data moved without a write");
    a_addr_only_cmd: assert property (!req |-> $stable(reg_req.addr))
        else $error("address moved without a command");
    a_err_one_pulse: assert property (frame_error |=> !frame_error)
        else $error("frame error longer than one cycle");
    a_err_no_cmd: assert property (frame_error |-> !req)
        else $error("short frame produced a command");
    c_write: cover property (reg_req.wr);
    c_read: cover property (reg_req.rd);
    c_short: cover property (frame_error);
endmodule

bind sdp_top sdp_top_props #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_props (
    .mclk(mclk), .nrst(nrst), .sck(sck), .select_low(select_low), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n), .status_flags(status_flags),
    .reg_rdata(reg_rdata), .reg_req(reg_req), .frame_error(frame_error)
);

// [verification/sdp_master.sv]
// serial master model sending mode-3 frames of any length
`timescale 1ns/1ps
module sdp_master (
    input  wire logic mclk,
    output logic      sck,
    output logic      select_low,
    output logic      serial_in,
    input  wire logic serial_out
);
    // link idles with clock high and no device selected
    initial begin
        sck        = 1'b1;
        select_low = 1'b1;
        serial_in  = 1'b0;
    end
    // msb first, select held low for all n clocks
    task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
        rx = '0;
        @(posedge mclk) select_low <= 1'b0;
        repeat (6) @(posedge mclk);
        // low phase kept longer so the answer bit has settled before the rise
        for (int i = n - 1; i >= 0; i--) begin
            sck       <= 1'b0;
            serial_in <= tx[i];
            repeat (5) @(posedge mclk);
            rx = {rx[62:0], serial_out};
            sck <= 1'b1;
            repeat (3) @(posedge mclk);
        end
        // released data line flips so a stale bit is never mistaken for data
        select_low <= 1'b1;
        serial_in  <= ~tx[0];
        repeat (8) @(posedge mclk);
    endtask
endmodule

// [verification/testbench.sv]
// self-checking bench for the serial datagram slave
`timescale 1ns/1ps
module testbench;
    logic                 mclk;
    logic                 nrst;
    logic                 sck;
    logic                 select_low;
    logic                 serial_in;
    logic                 serial_out;
    logic                 serial_out_oe_n;
    sdp_pkg::sdp_status_s status_flags;
    logic [31:0]          reg_rdata;
    sdp_pkg::sdp_req_s    reg_req;
    logic                 frame_error;
    logic                 sdo_line;
    logic [31:0]          regs [128];
    logic [31:0]          shadow [128];
    logic [31:0]          rd_q;
    logic [7:0]           stat_q;
    int                   mismatches = 0;
    int                   total_checks = 0;
    int                   err_seen = 0;

    sdp_top dut (
        .mclk(mclk), .nrst(nrst), .sck(sck), .select_low(select_low), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n), .status_flags(status_flags),
        .reg_rdata(reg_rdata), .reg_req(reg_req), .frame_error(frame_error)
    );
    // a released data line shows the inverse of the last bit, so a late enable is caught
    assign sdo_line = serial_out_oe_n ? ~serial_out : serial_out;
    sdp_master u_master (
        .mclk(mclk), .sck(sck), .select_low(select_low), .serial_in(serial_in),
        .serial_out(sdo_line)
    );

    // 125 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // far-side register file; read data follows the address at once
    assign reg_rdata = regs[reg_req.addr];
    always @(posedge mclk) begin
        if (reg_req.wr === 1'b1) regs[reg_req.addr] <= reg_req.wdata;
        if (frame_error === 1'b1) err_seen <= err_seen + 1;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one frame; answer is the previous status and readback, extras delayed by 40
    task automatic frame(input logic [63:0] tx, input int n, input logic [7:0] flags);
        logic [63:0] rx;
        logic [63:0] ex;
        logic [39:0] cmd;
        status_flags <= flags;
        ex = (n >= 40) ? (({stat_q, rd_q} << (n - 40)) | (tx >> 40)) : ({stat_q, rd_q} >> (40 - n));
        u_master.xfer(tx, n, rx);
        chk(rx, ex);
        cmd    = tx[39:0];
        stat_q = flags;
        if (n >= 40) begin
            if (cmd[39]) shadow[cmd[38:32]] = cmd[31:0];
            rd_q = cmd[39] ? cmd[31:0] : shadow[cmd[38:32]];
        end
        chk(regs[cmd[38:32]], shadow[cmd[38:32]]);
    endtask

    // write, read the same place with dummy ones, then collect it
    task automatic s_write_read();
        frame({8'hA2, 32'h12345678}, 40, 8'h5A);
        frame({8'h22, 32'hFFFFFFFF}, 40, 8'hA5);
        frame({8'h22, 32'h00000000}, 40, 8'h00);
    endtask

    // chained reads while one status flag at a time is raised, then all eight at once
    task automatic s_chain_status();
        for (int i = 0; i < 8; i++) frame({1'b0, 7'(i + 5), 32'h0}, 40, 8'h01 << i);
        frame({8'h7F, 32'h0}, 40, 8'hFF);
    endtask

    // 48 clocks: first byte leaves late, last 40 bits form the command
    task automatic s_long_frame();
        frame({8'h3C, 8'h91, 32'hCAFEF00D}, 48, 8'h81);
        frame({8'h11, 32'h0}, 40, 8'h00);
        frame({8'h00, 32'h0}, 40, 8'h00);
    endtask

    // short frame is refused, readback kept, status still latched
    task automatic s_short_frame();
        int e;
        e = err_seen;
        frame(64'hABCDE, 20, 8'h3C);
        chk(err_seen - e, 1);
        frame({8'h05, 32'h0}, 40, 8'h00);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        end_sim();
    end

    // reset, then the scenarios in turn
    initial begin
        nrst         = 1'b0;
        status_flags = '0;
        rd_q         = sdp_pkg::READBACK_RST;
        stat_q       = sdp_pkg::STAT_RST;
        for (int i = 0; i < 128; i++) begin
            regs[i]   = 32'hC0DE0000 + i;
            shadow[i] = regs[i];
        end
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        s_write_read();
        s_chain_status();
        s_long_frame();
        s_short_frame();
        end_sim();
    end
endmodule
